/* File: verilog/supervisor_pkg.sv */
/*
  constants and carrier types for the supply supervisor and watchdog.
  assumes a single 25 MHz system clock; all times become cycle counts here.
*/
package supervisor_pkg;
  localparam longint CLK_HZ = 25000000;
  localparam longint RESET_HOLD_MS = 200;
  localparam longint WD_PERIOD_MS = 1600;
  localparam longint MR_MIN_NS = 550;
  localparam longint KICK_MIN_NS = 100;
  localparam longint RESET_HOLD_CYC = RESET_HOLD_MS * CLK_HZ / 1000;
  localparam longint WD_PERIOD_CYC = WD_PERIOD_MS * CLK_HZ / 1000;
  // debounce window: the shortest recognised manual pulse, rounded down
  localparam longint MR_DEB_CYC = MR_MIN_NS * CLK_HZ / 1000000000;
  localparam longint KICK_MIN_CYC = (KICK_MIN_NS * CLK_HZ + 999999999) / 1000000000;
  localparam int CNT_W = 32;
  localparam int DEB_W = 8;
  localparam int SYNC_STAGES = 2;
  localparam logic [DEB_W-1:0] DEB_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;

  // comparator and strap indications, already synchronous
  typedef struct packed {
    logic supply_low;
    logic aux_voltage_in;
    logic wd_disable;
  } monitor_in_t;

  // reset and flag outputs
  typedef struct packed {
    logic sys_reset_n;
    logic sys_reset;
    logic wd_expired_n_out;
    logic aux_fail_flag_out;
  } supervisor_out_t;

  typedef enum logic [1:0] {ST_HOLD, ST_TIMING, ST_RUN} reset_state_t;
endpackage

/* File: verilog/supply_supervisor_watchdog.sv */
/*
  supply supervisor with reset stretcher, debounced manual reset, watchdog.
  assumes comparator results arrive as synchronous levels in monitor_in_t and
  that the manual reset and kick pins are asynchronous to clk.
*/
`timescale 1ns/1ps
// Contract
// R1 - reset asserts while the manual reset input is low
// R2 - manual reset input is debounced so bounce gives one event
// R3 - reset asserts at power-up
// R4 - reset asserts again whenever supply is below trip level
// R5 - reset held nominally 200ms after supply good or manual release
// R6 - power-fail flag follows the auxiliary comparator
// R7 - watchdog of nominal 1.6s drives its flag low on expiry
// R8 - any kick edge clears the watchdog; host must toggle in time
// R9 - manual reset clears the watchdog
// R10 - watchdog disabled when the kick pin floats; the code disables it from the mon.wd_disable strap input instead
// R11 - watchdog expiry alone never asserts system reset
// R12 - active-high reset is always the complement of active-low reset
// R13 - after expiry the watchdog restarts and signals again until cleared
// R14 - watchdog flag low whenever supply is below threshold
// R15 - watchdog flag released at once when supply returns
// R16 - manual reset must be held low at least 550ns
// R17 - kick pulses of 100ns or more are recognised
// R18 - analog indications are synchronous inputs; intervals come from counters
// R19 - manual reset and kick are synchronised before use
module supply_supervisor_watchdog
  import supervisor_pkg::*;
#(
  parameter logic [CNT_W-1:0] HOLD_CYCLES = CNT_W'(RESET_HOLD_CYC),
  parameter logic [CNT_W-1:0] WD_CYCLES = CNT_W'(WD_PERIOD_CYC),
  parameter logic [DEB_W-1:0] DEB_CYCLES = DEB_W'(MR_DEB_CYC)
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic manual_reset_n_in,
  input wire logic wd_kick_in,
  input wire monitor_in_t mon,
  output supervisor_out_t outs
);
  // elaboration checks: zero counts cannot time anything
  if (HOLD_CYCLES == CNT_ZERO || WD_CYCLES == CNT_ZERO ||
      DEB_CYCLES == DEB_ZERO) begin : g_bad_count
    $error("supervisor counts must be nonzero");
  end
  // a kick shorter than one clock period could fall between two edges (ns per s)
  if (KICK_MIN_NS * CLK_HZ < 64'h0000_0000_3B9A_CA00) begin : g_slow_clk
    $error("clock too slow to see shortest kick");
  end
  // a debounce longer than the shortest legal press would drop valid presses
  if (longint'(DEB_CYCLES) > MR_DEB_CYC) begin : g_long_deb
    $error("debounce longer than shortest manual reset");
  end

  logic [SYNC_STAGES-1:0] mr_sync_q;
  logic [SYNC_STAGES-1:0] kick_sync_q;
  logic kick_prev_q;
  logic mr_low_q;
  logic [DEB_W-1:0] deb_cnt_q;
  logic [CNT_W-1:0] hold_cnt_q;
  logic [CNT_W-1:0] wd_cnt_q;
  logic wd_pulse_q;
  reset_state_t state_q;
  logic kick_edge;
  logic mr_raw;
  logic cause;

  // two-stage synchronisers; stage 0 is read only by stage 1
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mr_sync_q <= '1;
      kick_sync_q <= '0;
    end else begin
      mr_sync_q <= {mr_sync_q[0], manual_reset_n_in}; // R19
      kick_sync_q <= {kick_sync_q[0], wd_kick_in}; // R19
    end
  end

  assign mr_raw = ~mr_sync_q[SYNC_STAGES-1];
  assign kick_edge = kick_sync_q[SYNC_STAGES-1] ^ kick_prev_q; // R8 R17

  // debounce: a new level is accepted only after it stands DEB_CYCLES
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mr_low_q <= 1'b0;
      deb_cnt_q <= DEB_ZERO;
    end else if (mr_raw == mr_low_q) begin
      deb_cnt_q <= DEB_ZERO;
    end else if (deb_cnt_q == DEB_CYCLES - 8'h01) begin
      mr_low_q <= mr_raw; // R2
      deb_cnt_q <= DEB_ZERO;
    end else begin
      deb_cnt_q <= deb_cnt_q + 8'h01;
    end
  end

  // reset causes; watchdog expiry is deliberately not among them
  assign cause = mon.supply_low | mr_low_q; // R1 R4 R11

  // reset stretcher: sys_rst models power-up, so it starts in hold
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= ST_HOLD; // R3
      hold_cnt_q <= CNT_ZERO;
    end else begin
      case (state_q)
        ST_HOLD: begin
          hold_cnt_q <= CNT_ZERO;
          if (!cause)
            state_q <= ST_TIMING;
        end
        ST_TIMING: begin
          if (cause) begin
            state_q <= ST_HOLD;
          end else if (hold_cnt_q == HOLD_CYCLES - CNT_ONE) begin
            state_q <= ST_RUN; // R5
          end else begin
            hold_cnt_q <= hold_cnt_q + CNT_ONE;
          end
        end
        ST_RUN: begin
          if (cause)
            state_q <= ST_HOLD; // R1 R4
        end
        default: state_q <= ST_HOLD;
      endcase
    end
  end

  // kick history
  always_ff @(posedge clk) begin
    if (sys_rst)
      kick_prev_q <= 1'b0;
    else
      kick_prev_q <= kick_sync_q[SYNC_STAGES-1];
  end

  // watchdog counter: restarts on kick, manual reset, disable or each expiry
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wd_cnt_q <= CNT_ZERO;
      wd_pulse_q <= 1'b0;
    end else if (kick_edge || mr_low_q || mon.wd_disable) begin
      wd_cnt_q <= CNT_ZERO; // R8 R9 R10
      wd_pulse_q <= 1'b0;
    end else if (wd_cnt_q == WD_CYCLES - CNT_ONE) begin
      wd_cnt_q <= CNT_ZERO; // R13
      wd_pulse_q <= 1'b1; // R7
    end else begin
      wd_cnt_q <= wd_cnt_q + CNT_ONE;
      wd_pulse_q <= 1'b0;
    end
  end

  // registered outputs; both reset polarities come from the same next value
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      outs.sys_reset_n <= 1'b0;
      outs.sys_reset <= 1'b1;
      outs.wd_expired_n_out <= 1'b0;
      outs.aux_fail_flag_out <= 1'b0;
    end else begin
      outs.sys_reset_n <= (state_q == ST_RUN) && !cause; // R12
      outs.sys_reset <= !((state_q == ST_RUN) && !cause); // R12
      outs.wd_expired_n_out <= !mon.supply_low && !wd_pulse_q; // R14 R15 R7
      outs.aux_fail_flag_out <= mon.aux_voltage_in; // R6 R18
    end
  end

  property p_complement;
    @(posedge clk) disable iff (sys_rst) outs.sys_reset == !outs.sys_reset_n;
  endproperty
  a_complement: assert property (p_complement) else $error("reset outputs not complementary"); // R12

  property p_supply_reset;
    @(posedge clk) disable iff (sys_rst) mon.supply_low |=> !outs.sys_reset_n;
  endproperty
  a_supply_reset: assert property (p_supply_reset) else $error("supply low gave no reset"); // R4

  property p_manual_reset;
    @(posedge clk) disable iff (sys_rst) mr_low_q |=> !outs.sys_reset_n;
  endproperty
  a_manual_reset: assert property (p_manual_reset) else $error("manual reset gave no reset"); // R1

  property p_wd_supply;
    @(posedge clk) disable iff (sys_rst) mon.supply_low |=> !outs.wd_expired_n_out;
  endproperty
  a_wd_supply: assert property (p_wd_supply) else $error("watchdog flag high at low supply"); // R14

  property p_wd_release;
    @(posedge clk) disable iff (sys_rst)
      (!mon.supply_low && !wd_pulse_q) |=> outs.wd_expired_n_out;
  endproperty
  a_wd_release: assert property (p_wd_release) else $error("watchdog flag not released"); // R15

  property p_aux;
    @(posedge clk) disable iff (sys_rst)
      !$past(sys_rst) |-> outs.aux_fail_flag_out == $past(mon.aux_voltage_in);
  endproperty
  a_aux: assert property (p_aux) else $error("power-fail flag mismatch"); // R6

  property p_kick_clear;
    @(posedge clk) disable iff (sys_rst) kick_edge |=> wd_cnt_q == CNT_ZERO;
  endproperty
  a_kick_clear: assert property (p_kick_clear) else $error("kick did not clear watchdog"); // R8

  property p_mr_clear;
    @(posedge clk) disable iff (sys_rst) mr_low_q |=> wd_cnt_q == CNT_ZERO && !wd_pulse_q;
  endproperty
  a_mr_clear: assert property (p_mr_clear) else $error("manual reset did not clear watchdog"); // R9

  property p_disable;
    @(posedge clk) disable iff (sys_rst) mon.wd_disable |=> !wd_pulse_q;
  endproperty
  a_disable: assert property (p_disable) else $error("disabled watchdog expired"); // R10

  sequence s_expire;
    wd_pulse_q && !mon.supply_low;
  endsequence
  property p_no_wd_reset;
    @(posedge clk) disable iff (sys_rst)
      (s_expire ##0 (state_q == ST_RUN && !mon.supply_low && !mr_low_q)) |=> outs.sys_reset_n;
  endproperty
  a_no_wd_reset: assert property (p_no_wd_reset) else $error("watchdog caused reset"); // R11

  property p_wd_restart;
    @(posedge clk) disable iff (sys_rst) wd_pulse_q |-> wd_cnt_q == CNT_ZERO;
  endproperty
  a_wd_restart: assert property (p_wd_restart) else $error("watchdog did not restart"); // R13
endmodule

/* File: tb/host_model.sv */
/*
  host processor model: kicks the watchdog by toggling its pin.
  assumes kicks are wanted only while kick_en is high and reset is released.
*/
`timescale 1ns/1ps
module host_model
  import supervisor_pkg::*;
#(
  parameter int KICK_GAP = 20
) (
  input wire logic clk,
  input wire logic kick_en,
  input wire supervisor_out_t outs,
  output logic wd_kick_in
);
  logic kick_q = 1'b0;
  int gap_q = 0;
  // one driver for the kick pin
  assign wd_kick_in = kick_q;
  // toggle the kick pin well inside the watchdog period, never in reset
  always @(negedge clk) begin
    if (kick_en && outs.sys_reset_n === 1'b1) begin
      gap_q = gap_q + 1;
      if (gap_q >= KICK_GAP) begin
        gap_q = 0;
        kick_q <= ~kick_q;
      end
    end
  end
endmodule

/* File: tb/supply_supervisor_watchdog_test.sv */
/*
  self-checking bench for the supervisor with short hold and watchdog counts.
  assumes the host model kicks on request; inputs change at falling edges.
*/
`timescale 1ns/1ps
module supply_supervisor_watchdog_test
  import supervisor_pkg::*;
;
  localparam int HOLD = 20;
  localparam int WD = 50;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic manual_reset_n_in = 1'b1;
  logic kick_en = 1'b0;
  logic wd_kick_in;
  monitor_in_t mon = 3'h1;
  supervisor_out_t outs;
  int fail_count = 0;
  int checks_done = 0;
  int n;
  supply_supervisor_watchdog #(.HOLD_CYCLES(CNT_W'(HOLD)), .WD_CYCLES(CNT_W'(WD)))
    supply_supervisor_watchdog_inst (.clk(clk), .sys_rst(sys_rst),
    .manual_reset_n_in(manual_reset_n_in), .wd_kick_in(wd_kick_in), .mon(mon), .outs(outs));
  host_model host_model_inst (.clk(clk), .kick_en(kick_en), .outs(outs), .wd_kick_in(wd_kick_in));
  // 25 MHz clock
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check_bit(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic check_span(input string what, input int lo, input int hi, input int got);
    checks_done++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic step(input int c);
    repeat (c) @(negedge clk);
  endtask
  // cycles until reset (wd=0) or watchdog flag (wd=1) reaches v
  task automatic wait_out(input bit wd, input logic v, input int lim, output int c);
    c = 0;
    while ((wd ? outs.wd_expired_n_out : outs.sys_reset_n) !== v && c < lim) begin
      step(1);
      c++;
    end
  endtask
  task automatic supply_dip();
    mon.supply_low = 1'b1;
    step(2);
    check_bit("reset_n", 1'b0, outs.sys_reset_n);
    check_bit("wd_n low", 1'b0, outs.wd_expired_n_out);
    step(5);
    mon.supply_low = 1'b0;
    step(2);
    check_bit("wd_n back", 1'b1, outs.wd_expired_n_out);
    check_bit("reset held", 1'b1, outs.sys_reset);
    wait_out(0, 1'b1, 100, n);
    check_span("supply hold", HOLD - 2, HOLD + 2, n);
    check_bit("reset_hi", 1'b0, outs.sys_reset);
  endtask
  task automatic manual_press();
    manual_reset_n_in = 1'b0;
    step(5);
    manual_reset_n_in = 1'b1;
    step(20);
    check_bit("bounce", 1'b1, outs.sys_reset_n);
    manual_reset_n_in = 1'b0;
    step(20);
    check_bit("manual", 1'b0, outs.sys_reset_n);
    check_bit("manual hi", 1'b1, outs.sys_reset);
    manual_reset_n_in = 1'b1;
    wait_out(0, 1'b1, HOLD + 40, n);
    check_span("manual hold", HOLD, HOLD + 20, n);
  endtask
  // counts cycles with the flag not high over a span and whether reset ever asserted
  task automatic count_low(input int c, output int lows, output logic rst_seen);
    lows = 0;
    rst_seen = 1'b0;
    repeat (c) begin
      step(1);
      if (outs.wd_expired_n_out !== 1'b1) lows++;
      if (outs.sys_reset_n !== 1'b1) rst_seen = 1'b1;
    end
  endtask
  task automatic watchdog();
    logic r;
    mon.wd_disable = 1'b0;
    wait_out(1, 1'b0, WD + 10, n);
    check_span("expiry", WD - 1, WD + 4, n);
    check_bit("no wd reset", 1'b1, outs.sys_reset_n);
    step(1);
    wait_out(1, 1'b0, WD + 10, n);
    check_span("repeat", WD - 2, WD + 2, n);
    kick_en = 1'b1;
    count_low(3 * WD, n, r);
    check_span("kicked", 0, 0, n);
    check_bit("kick rst", 1'b0, r);
    kick_en = 1'b0;
    wait_out(1, 1'b0, WD + 10, n);
    step(25);
    manual_reset_n_in = 1'b0;
    step(20);
    manual_reset_n_in = 1'b1;
    wait_out(1, 1'b0, WD + 40, n);
    check_span("manual clear", WD - 2, WD + 30, n);
    mon.wd_disable = 1'b1;
    count_low(2 * WD, n, r);
    check_span("disabled", 0, 0, n);
    check_bit("off rst", 1'b0, r);
  endtask
  task automatic aux_follow();
    for (int i = 0; i < 3; i++) begin
      mon.aux_voltage_in = i[0];
      step(2);
      check_bit("aux flag", i[0], outs.aux_fail_flag_out);
    end
  endtask
  // main sequence: power-up hold first, then each scenario
  initial begin
    step(8);
    sys_rst = 1'b0;
    step(1);
    check_bit("por", 1'b0, outs.sys_reset_n);
    wait_out(0, 1'b1, 100, n);
    check_span("por hold", HOLD - 1, HOLD + 4, n);
    supply_dip();
    manual_press();
    aux_follow();
    watchdog();
    finish_test();
  end
  // watchdog on the run itself
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    finish_test();
  end
endmodule
